// ---- hw/packet_queue_rx_tx_service.sv ----
// Purpose: receive packet queueing and transmit completion service
// Assumes: one clock, receive words arrive synchronous to aclk
// Notes: Operation
// Operation
// - matching frame gets packet number and pages
// - dma writes sequential offsets, translated to memory
// - overrun drops frame and frees its memory
// - status word goes to packet word zero
// - byte count goes to packet word one
// - good frame check queues packet number
// - receive flag set while receive queue nonempty
// - bad frame check frees memory, queues nothing
// - receive queue head readable in ports register
// - remove command pops queue and frees packet
// - byte 0x02 to interrupt register acks transmit
// - link status bit zero shows last send ok
// - command 0x00A0 frees selected packet
// - command 0x00C0 requeues selected packet for sending
// - ports register low six bits: completion queue head packet
// - transmit flag set while completion queue nonempty
// - failure clears run bit, sending stops
// - auto release frees good packets, no completion
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

// small packet-number queue, head shown combinationally
module pq_fifo #(
	parameter int W = 6,
	parameter int DEPTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic push,
	input wire logic [W-1:0] din,
	input wire logic pop,
	output logic [W-1:0] dout,
	output logic empty,
	output logic full
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic do_push;
	logic do_pop;

	assign empty = (cnt_r == '0);
	assign full = (cnt_r == (AW+1)'(DEPTH));
	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	assign dout = mem[rp_r];

	// pointers and fill level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (do_push)
				wp_r <= wp_r + 1'b1;
			if (do_pop)
				rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	// storage needs no reset
	always_ff @(posedge aclk) begin
		if (do_push)
			mem[wp_r] <= din;
	end
endmodule

module packet_queue_rx_tx_service import pq_pkg::*; #(
	parameter int NPKT = 16,
	parameter int PKT_WORDS = 1024,
	parameter int PAGE_WORDS = 128,
	parameter int NUM_PAGES = 24,
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite register port
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// receive word stream from the line side
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic rx_eof,
	input wire logic [15:0] rx_data,
	input wire logic rx_addr_match,
	input wire logic rx_overrun,
	input wire logic rx_fcs_ok,
	input wire logic [15:0] rx_status,
	input wire logic [15:0] rx_byte_count,
	// transmit engine handshake
	output logic tx_start,
	output logic [5:0] tx_pkt,
	input wire logic tx_done,
	input wire logic tx_ok,
	// queue flags
	output logic receive_queue_flag,
	output logic transmit_done_flag
);
	localparam int PI_W = $clog2(NPKT);
	localparam int OFF_W = $clog2(PKT_WORDS);
	localparam int PG_W = $clog2(NUM_PAGES + 1);

	logic [15:0] mem [NPKT*PKT_WORDS];
	logic [NPKT-1:0] busy_r;
	logic [PG_W-1:0] pkt_pages_r [NPKT];
	logic [PG_W-1:0] free_pages_r;
	rx_state_t rx_state_r;
	logic [PI_W-1:0] cur_pkt_r;
	logic [OFF_W-1:0] off_r;
	logic [15:0] stat_r;
	logic [15:0] count_r;
	logic fcs_r;
	logic [15:0] transmit_control_r;
	logic [15:0] rx_control_r;
	logic [5:0] packet_number_select_r;
	logic [1:0] bank_r;
	logic [OFF_W-1:0] pointer_r;
	logic last_ok_r;
	logic tx_busy_r;
	// bus slave state
	logic aw_hold_r;
	logic w_hold_r;
	logic [3:0] aw_idx_r;
	logic aw_bad_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_fire;
	logic wr_ok;
	logic [3:0] ar_idx;
	logic [15:0] rd_val;
	logic rd_ok;
	// queues and commands
	logic [5:0] rxq_head;
	logic rxq_empty;
	logic rxq_push;
	logic rxq_pop;
	logic [5:0] txq_head;
	logic txq_empty;
	logic txq_push;
	logic txq_pop;
	logic [5:0] cq_head;
	logic cq_empty;
	logic cq_push;
	logic cq_pop;
	logic cmd_rel;
	logic cmd_rx_rem;
	logic [NPKT-1:0] rel_mask;
	logic [NPKT-1:0] alloc_mask;
	logic [PI_W-1:0] free_idx;
	logic free_any;
	logic page_take;
	logic rx_drop;
	logic rx_rel_bad;
	logic auto_rel;
	logic [PG_W-1:0] pages_back;
	logic mem_we;
	logic [OFF_W-1:0] mem_off;
	logic [15:0] mem_wdata;

	function automatic logic [15:0] merge(input logic [15:0] old,
			input logic [31:0] d, input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic [NPKT-1:0] onehot(input logic [5:0] n);
		onehot = '0;
		onehot[n[PI_W-1:0]] = 1'b1;
	endfunction

	// register exists at this bank and index
	function automatic logic mapped(input logic [1:0] b,
			input logic [3:0] i);
		mapped = (i == IDX_BANK) ||
			(b == BANK_0 && (i == IDX_TX_CONTROL ||
			i == IDX_LINK_STATUS || i == IDX_RX_CONTROL)) ||
			(b == BANK_2 && (i == IDX_COMMAND || i == IDX_PKT_SELECT ||
			i == IDX_HEAD_PORTS || i == IDX_POINTER ||
			i == IDX_DATA || i == IDX_INT_STATUS));
	endfunction

	// lowest free packet number
	always_comb begin
		free_idx = '0;
		free_any = 1'b0;
		for (int i = NPKT - 1; i >= 0; i--) begin
			if (!busy_r[i]) begin
				free_idx = PI_W'(i);
				free_any = 1'b1;
			end
		end
	end

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
	assign wr_fire = aw_hold_r && w_hold_r;
	assign wr_ok = !aw_bad_r && mapped(bank_r, aw_idx_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_idx_r <= '0;
			aw_bad_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr[5:2];
				aw_bad_r <= (s_axi_awaddr >> 6) != '0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read mux, decoded through the bank held now
	assign ar_idx = s_axi_araddr[5:2];
	assign rd_ok = ((s_axi_araddr >> 6) == '0) && mapped(bank_r, ar_idx);
	always_comb begin
		rd_val = '0;
		if (ar_idx == IDX_BANK) begin
			rd_val = {14'h0000, bank_r};
		end else if (bank_r == BANK_0) begin
			unique case (ar_idx)
				IDX_TX_CONTROL: rd_val = transmit_control_r;
				IDX_LINK_STATUS: rd_val = {15'h0000, last_ok_r};
				IDX_RX_CONTROL: rd_val = rx_control_r;
				default: rd_val = '0;
			endcase
		end else if (bank_r == BANK_2) begin
			unique case (ar_idx)
				IDX_PKT_SELECT: rd_val = {10'h000, packet_number_select_r};
				// receive head above, completion head below
				IDX_HEAD_PORTS: rd_val = {rxq_empty, 1'b0, rxq_head,
					cq_empty, 1'b0, cq_head};
				IDX_POINTER: rd_val = 16'(pointer_r);
				IDX_DATA: rd_val = mem[{packet_number_select_r[PI_W-1:0],
					pointer_r}];
				IDX_INT_STATUS: rd_val = {14'h0000, transmit_done_flag,
					receive_queue_flag};
				default: rd_val = '0;
			endcase
		end
	end

	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {16'h0000, rd_ok ? rd_val : 16'h0000};
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// command strobes from accepted bank 2 writes
	always_comb begin
		cmd_rel = 1'b0;
		cmd_rx_rem = 1'b0;
		txq_push = 1'b0;
		cq_pop = 1'b0;
		if (wr_fire && wr_ok && bank_r == BANK_2 && wstrb_r[0]) begin
			if (aw_idx_r == IDX_COMMAND) begin
				cmd_rel = wdata_r[15:0] == CMD_RELEASE;
				txq_push = wdata_r[15:0] == CMD_ENQUEUE;
				cmd_rx_rem = wdata_r[15:0] == CMD_RX_REMOVE;
			end
			if (aw_idx_r == IDX_INT_STATUS)
				cq_pop = wdata_r[INT_TX_BIT];
		end
	end

	// software registers; the hardware clear of the run bit wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			transmit_control_r <= TX_CONTROL_RST;
			rx_control_r <= RX_CONTROL_RST;
			packet_number_select_r <= PKT_SELECT_RST;
			bank_r <= BANK_RST;
			pointer_r <= '0;
		end else begin
			if (wr_fire && wr_ok) begin
				if (aw_idx_r == IDX_BANK && wstrb_r[0])
					bank_r <= wdata_r[1:0];
				else if (bank_r == BANK_0 && aw_idx_r == IDX_TX_CONTROL)
					transmit_control_r <= merge(transmit_control_r,
						wdata_r, wstrb_r);
				else if (bank_r == BANK_0 && aw_idx_r == IDX_RX_CONTROL)
					rx_control_r <= merge(rx_control_r, wdata_r, wstrb_r);
				else if (bank_r == BANK_2 && aw_idx_r == IDX_PKT_SELECT &&
					wstrb_r[0])
					packet_number_select_r <= wdata_r[5:0];
				else if (bank_r == BANK_2 && aw_idx_r == IDX_POINTER)
					pointer_r <= wdata_r[OFF_W-1:0];
			end
			if (tx_busy_r && tx_done && !tx_ok)
				transmit_control_r[RUN_BIT] <= 1'b0;
		end
	end

	// receive frame sequencer
	assign page_take = rx_state_r == RX_DATA && rx_valid && !rx_overrun &&
		off_r[$clog2(PAGE_WORDS)-1:0] == '0 && free_pages_r != '0;
	assign rx_drop = rx_state_r == RX_DATA && (rx_overrun ||
		(rx_valid && off_r[$clog2(PAGE_WORDS)-1:0] == '0 &&
		free_pages_r == '0) ||
		(rx_valid && !rx_eof && off_r == '1));
	assign rx_rel_bad = rx_state_r == RX_DONE && !fcs_r;
	assign rxq_push = rx_state_r == RX_DONE && fcs_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state_r <= RX_IDLE;
			cur_pkt_r <= '0;
			off_r <= '0;
			stat_r <= '0;
			count_r <= '0;
			fcs_r <= 1'b0;
		end else begin
			unique case (rx_state_r)
				RX_IDLE: begin
					// frames are kept only when receive is enabled
					if (rx_valid && rx_sof && rx_addr_match && free_any &&
						free_pages_r != '0 &&
						rx_control_r[RX_EN_BIT]) begin
						cur_pkt_r <= free_idx;
						off_r <= OFF_W'(DATA_START + 1);
						stat_r <= rx_status;
						count_r <= rx_byte_count;
						fcs_r <= rx_fcs_ok;
						rx_state_r <= rx_eof ? RX_STAT : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_drop) begin
						rx_state_r <= RX_IDLE;
					end else if (rx_valid) begin
						off_r <= off_r + 1'b1;
						if (rx_eof) begin
							stat_r <= rx_status;
							count_r <= rx_byte_count;
							fcs_r <= rx_fcs_ok;
							rx_state_r <= RX_STAT;
						end
					end
				end
				RX_STAT: rx_state_r <= RX_CNT;
				RX_CNT: rx_state_r <= RX_DONE;
				RX_DONE: rx_state_r <= RX_IDLE;
				default: rx_state_r <= RX_IDLE;
			endcase
		end
	end

	// memory write port: packet number selects the region
	always_comb begin
		mem_we = 1'b0;
		mem_off = off_r;
		mem_wdata = rx_data;
		if (rx_state_r == RX_IDLE) begin
			mem_we = rx_valid && rx_sof && rx_addr_match && free_any &&
				free_pages_r != '0 && rx_control_r[RX_EN_BIT];
			mem_off = OFF_W'(DATA_START);
		end else if (rx_state_r == RX_DATA) begin
			mem_we = rx_valid && !rx_drop;
		end else if (rx_state_r == RX_STAT) begin
			mem_we = 1'b1;
			mem_off = OFF_W'(STATUS_WORD);
			mem_wdata = stat_r;
		end else if (rx_state_r == RX_CNT) begin
			mem_we = 1'b1;
			mem_off = OFF_W'(COUNT_WORD);
			mem_wdata = count_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (mem_we) begin
			if (rx_state_r == RX_IDLE)
				mem[{free_idx, mem_off}] <= mem_wdata;
			else
				mem[{cur_pkt_r, mem_off}] <= mem_wdata;
		end
	end

	// packet and page bookkeeping; all frees merge into one mask
	assign alloc_mask = (rx_state_r == RX_IDLE && mem_we) ?
		onehot(6'(free_idx)) : '0;
	assign rxq_pop = cmd_rx_rem;
	always_comb begin
		rel_mask = '0;
		if (rx_drop || rx_rel_bad)
			rel_mask = rel_mask | onehot(6'(cur_pkt_r));
		if (cmd_rx_rem && !rxq_empty)
			rel_mask = rel_mask | onehot(rxq_head);
		if (cmd_rel)
			rel_mask = rel_mask | onehot(packet_number_select_r);
		if (auto_rel)
			rel_mask = rel_mask | onehot(tx_pkt);
		pages_back = '0;
		for (int i = 0; i < NPKT; i++) begin
			if (rel_mask[i] && busy_r[i])
				pages_back = pages_back + pkt_pages_r[i];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_r <= '0;
			free_pages_r <= PG_W'(NUM_PAGES);
			for (int i = 0; i < NPKT; i++)
				pkt_pages_r[i] <= '0;
		end else begin
			busy_r <= (busy_r & ~rel_mask) | alloc_mask;
			free_pages_r <= free_pages_r + pages_back -
				PG_W'(page_take) - PG_W'(alloc_mask != '0);
			for (int i = 0; i < NPKT; i++) begin
				if (alloc_mask[i])
					pkt_pages_r[i] <= PG_W'(1);
				else if (rel_mask[i])
					pkt_pages_r[i] <= '0;
				else if (page_take && cur_pkt_r == PI_W'(i))
					pkt_pages_r[i] <= pkt_pages_r[i] + 1'b1;
			end
		end
	end

	pq_fifo #(.W(6), .DEPTH(NPKT)) rx_queue (
		.aclk(aclk), .aresetn(aresetn),
		.push(rxq_push), .din(6'(cur_pkt_r)),
		.pop(rxq_pop), .dout(rxq_head),
		.empty(rxq_empty), .full()
	);

	pq_fifo #(.W(6), .DEPTH(NPKT)) tx_queue (
		.aclk(aclk), .aresetn(aresetn),
		.push(txq_push), .din(packet_number_select_r),
		.pop(txq_pop), .dout(txq_head),
		.empty(txq_empty), .full()
	);

	pq_fifo #(.W(6), .DEPTH(NPKT)) done_queue (
		.aclk(aclk), .aresetn(aresetn),
		.push(cq_push), .din(tx_pkt),
		.pop(cq_pop), .dout(cq_head),
		.empty(cq_empty), .full()
	);

	// transmit dispatch, one packet in flight at a time
	assign txq_pop = !tx_busy_r && !txq_empty &&
		transmit_control_r[RUN_BIT];
	assign auto_rel = tx_busy_r && tx_done && tx_ok &&
		transmit_control_r[AUTO_BIT];
	assign cq_push = tx_busy_r && tx_done && !auto_rel;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_busy_r <= 1'b0;
			tx_start <= 1'b0;
			tx_pkt <= '0;
			last_ok_r <= 1'b0;
		end else begin
			tx_start <= txq_pop;
			if (txq_pop) begin
				tx_busy_r <= 1'b1;
				tx_pkt <= txq_head;
			end else if (tx_busy_r && tx_done) begin
				tx_busy_r <= 1'b0;
				last_ok_r <= tx_ok;
			end
		end
	end

	// level flags follow queue occupancy
	assign receive_queue_flag = !rxq_empty;
	assign transmit_done_flag = !cq_empty;
endmodule
`default_nettype wire

// ---- hw/pq_pkg.sv ----
// Purpose: constants shared by the packet queue service block
// Assumes: 16-bit registers, one per aligned 32-bit bus word
// Notes: byte address of a register is four times its index
package pq_pkg;
	// register indexes, decoded together with the selected bank, except IDX_BANK, which is decoded in every bank
	localparam logic [3:0] IDX_TX_CONTROL = 4'h0;
	localparam logic [3:0] IDX_LINK_STATUS = 4'h2;
	localparam logic [3:0] IDX_RX_CONTROL = 4'h4;
	localparam logic [3:0] IDX_COMMAND = 4'h0;
	localparam logic [3:0] IDX_PKT_SELECT = 4'h2;
	localparam logic [3:0] IDX_HEAD_PORTS = 4'h4;
	localparam logic [3:0] IDX_POINTER = 4'h6;
	localparam logic [3:0] IDX_DATA = 4'h8;
	localparam logic [3:0] IDX_INT_STATUS = 4'hC;
	localparam logic [3:0] IDX_BANK = 4'hE;
	localparam logic [1:0] BANK_0 = 2'h0;
	localparam logic [1:0] BANK_2 = 2'h2;
	// buffer manager commands
	localparam logic [15:0] CMD_RX_REMOVE = 16'h0080;
	localparam logic [15:0] CMD_RELEASE = 16'h00A0;
	localparam logic [15:0] CMD_ENQUEUE = 16'h00C0;
	// field positions
	localparam int RUN_BIT = 0;
	localparam int AUTO_BIT = 1;
	localparam int RX_EN_BIT = 0;
	localparam int LINK_OK_BIT = 0;
	localparam int INT_RX_BIT = 0;
	localparam int INT_TX_BIT = 1;
	// values after reset
	localparam logic [15:0] TX_CONTROL_RST = 16'h0000;
	localparam logic [15:0] RX_CONTROL_RST = 16'h0000;
	localparam logic [5:0] PKT_SELECT_RST = 6'h00;
	localparam logic [1:0] BANK_RST = 2'h0;
	// word offsets inside a packet
	localparam int STATUS_WORD = 0;
	localparam int COUNT_WORD = 1;
	localparam int DATA_START = 2;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_DATA = 3'b001,
		RX_STAT = 3'b010,
		RX_CNT = 3'b011,
		RX_DONE = 3'b100
	} rx_state_t;
endpackage

// ---- tb/pq_props.sv ----
// Purpose: port assertions for the packet queue service block
// Assumes: top module ports only, one clock
// Notes: flag windows allow for the three-cycle frame tail
`timescale 1ns/100ps
`default_nettype none
module pq_props import pq_pkg::*; #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	// receive stream
	input wire logic rx_valid,
	input wire logic rx_eof,
	input wire logic rx_fcs_ok,
	// transmit handshake and flags
	input wire logic tx_start,
	input wire logic [5:0] tx_pkt,
	input wire logic tx_done,
	input wire logic tx_ok,
	input wire logic receive_queue_flag,
	input wire logic transmit_done_flag
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic eof_ok, eof_bad, fail;
	// frame ends and failed sends as seen at the ports
	assign eof_ok = rx_valid && rx_eof && rx_fcs_ok;
	assign eof_bad = rx_valid && rx_eof && !rx_fcs_ok;
	assign fail = tx_done && !tx_ok;
	rx_push_a: assert property (
		$rose(receive_queue_flag) |->
		$past(eof_ok, 3) || $past(eof_ok, 4) || $past(eof_ok, 5))
		else $error("receive flag rose without a good frame end");
	rx_bad_a: assert property (
		eof_bad && !receive_queue_flag |=> !receive_queue_flag[*5])
		else $error("bad frame raised the receive flag");
	rx_pop_a: assert property (
		$fell(receive_queue_flag) |-> s_axi_bvalid)
		else $error("receive flag dropped without a write");
	tx_ack_a: assert property (
		$fell(transmit_done_flag) |-> s_axi_bvalid)
		else $error("transmit flag dropped without a write");
	tx_comp_a: assert property (
		$rose(transmit_done_flag) |-> $past(tx_done) || $past(tx_done, 2))
		else $error("transmit flag rose without a completion");
	tx_fail_a: assert property (
		fail |-> ##[1:2] transmit_done_flag)
		else $error("failed send raised no transmit flag");
	tx_stop_a: assert property (
		fail |=> !tx_start[*4])
		else $error("sending went on after a failure");
	tx_pkt_a: assert property (
		$changed(tx_pkt) |-> tx_start)
		else $error("packet number moved without a start");
	unmap_a: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:6] != '0
		|=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR
		&& s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	// main scenarios reached
	cover property ($rose(receive_queue_flag));
	cover property (fail);
	cover property (tx_start);
endmodule
bind packet_queue_rx_tx_service pq_props #(.ADDR_W(ADDR_W)) i_pq_props (.*);
`default_nettype wire

// ---- tb/pq_sender.sv ----
// Purpose: sender model on the transmit side of the block
// Assumes: one send in flight, started by the tx_start pulse
// Notes: outcome and pace of each send are set by the bench
`timescale 1ns/100ps
`default_nettype none
module pq_sender (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// handshake with the block
	input wire logic tx_start,
	output logic tx_done,
	output logic tx_ok,
	// outcome and pace of the next send
	input wire logic fail_next,
	input wire logic [3:0] pace
);
	logic busy_r;
	logic [3:0] cnt_r;
	// count the send down, then pulse done with its outcome
	always_ff @(posedge aclk) begin
		tx_done <= 1'b0;
		tx_ok <= ~tx_ok; // outcome means nothing outside done
		if (!aresetn) begin
			busy_r <= 1'b0;
			cnt_r <= 4'h0;
			tx_ok <= 1'b0;
		end else if (tx_start) begin
			busy_r <= 1'b1;
			cnt_r <= pace;
		end else if (busy_r && cnt_r == 4'h0) begin
			busy_r <= 1'b0;
			tx_done <= 1'b1;
			tx_ok <= !fail_next;
		end else if (busy_r) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the packet queue service block
// Assumes: bench drives bus and receive stream, model plays sender
// Notes: lengths, data and numbers come from a fixed xorshift seed
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import pq_pkg::*;
	logic aclk, aresetn, fail_next;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [3:0] s_axi_wstrb, pace;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
	logic rx_valid, rx_sof, rx_eof, rx_addr_match, rx_overrun, rx_fcs_ok;
	logic [15:0] rx_data, rx_status, rx_byte_count, g, sv, st;
	logic tx_start, tx_done, tx_ok, receive_queue_flag, transmit_done_flag;
	logic [5:0] tx_pkt, lp, ha, p;
	logic [15:0] wq[$];
	int fail_count, checks, starts, fn;
	packet_queue_rx_tx_service i_packet_queue_rx_tx_service (.*);
	pq_sender i_pq_sender (.*);
	// 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// count hand-overs to the sender, keep the last number
	always @(posedge aclk) begin
		if (tx_start === 1'b1) begin
			starts++;
			lp = tx_pkt;
		end
	end
	function automatic int rn(input int m);
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return int'(seed[15:0]) % m;
	endfunction
	function automatic logic [7:0] ad(input logic [3:0] i);
		return {2'b00, i, 2'b00};
	endfunction
	// expected ports word, receive head masked off
	function automatic logic [15:0] ports(input logic re, input logic ce,
		input logic [5:0] ch);
		return {re, 7'h00, ce, 1'b0, ch};
	endfunction
	task automatic stop_test();
		if (fail_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	// handshakes are judged mid-cycle, released after the taking edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic ta, tw, pa, pw;
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		do begin
			@(negedge aclk);
			ta = s_axi_bvalid;
			bs = s_axi_bresp;
			@(posedge aclk);
		end while (ta !== 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		logic t;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			t = s_axi_arready;
			@(posedge aclk);
		end while (t !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			t = s_axi_rvalid;
			d = s_axi_rdata[15:0];
			rs = s_axi_rresp;
			@(posedge aclk);
		end while (t !== 1'b1);
	endtask
	task automatic bank(input logic [1:0] b);
		wr(ad(IDX_BANK), {14'h0000, b});
	endtask
	task automatic wait_tq(input int lim);
		for (int i = 0; i < lim && transmit_done_flag !== 1'b1; i++)
			@(posedge aclk);
	endtask
	// one frame, then the idle gap the tail needs
	task automatic frame(input int n, input logic m, input logic f,
		input logic o);
		logic [15:0] w;
		wq.delete();
		fn = n;
		st = 16'(rn(65536));
		for (int i = 0; i < n; i++) begin
			w = 16'(rn(65536));
			wq.push_back(w);
			rx_valid <= 1'b1;
			rx_sof <= (i == 0);
			rx_eof <= (i == n - 1);
			rx_data <= w;
			rx_addr_match <= m;
			rx_overrun <= o && (i == n / 2);
			rx_fcs_ok <= f;
			rx_status <= st;
			rx_byte_count <= 16'(2 * n);
			@(posedge aclk);
		end
		{rx_valid, rx_sof, rx_eof, rx_overrun} <= 4'h0;
		rx_data <= ~w; // idle line shows no stale word
		repeat (4) @(posedge aclk);
	endtask
	task automatic pkt_chk(input logic [5:0] n);
		logic [15:0] e;
		wr(ad(IDX_PKT_SELECT), {10'h000, n});
		for (int i = 0; i < fn + 2; i++) begin
			wr(ad(IDX_POINTER), 16'(i));
			rd(ad(IDX_DATA), g);
			e = (i == 0) ? st : (i == 1) ? 16'(2 * fn) : wq[i - 2];
			chk(g, e);
		end
	endtask
	task automatic send(input logic [5:0] n, input logic f);
		fail_next <= f;
		pace <= 4'(rn(16));
		wr(ad(IDX_PKT_SELECT), {10'h000, n});
		wr(ad(IDX_COMMAND), CMD_ENQUEUE);
		wait_tq(60);
	endtask
	// cut a hang short; the run needs far fewer cycles
	initial begin
		repeat (30000) @(posedge aclk);
		fail_count++;
		stop_test();
	end
	// main sequence
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, aresetn} = 4'h0;
		{rx_valid, rx_sof, rx_eof, rx_addr_match, rx_overrun} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{rx_data, rx_status, rx_byte_count, rx_fcs_ok, fail_next} = '0;
		{s_axi_bready, s_axi_rready} = 2'b11; // answers always taken
		s_axi_wstrb = 4'h3;
		pace = 4'h0;
		seed = 32'h0001_3A83;
		{fail_count, checks, starts} = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ad(IDX_TX_CONTROL), g);
		chk(g, TX_CONTROL_RST);
		rd(8'h40, g);
		chk(16'(rs), 16'(RESP_SLVERR));
		wr(8'h44, 16'h0001);
		chk(16'(bs), 16'(RESP_SLVERR));
		bank(BANK_2);
		rd(ad(IDX_HEAD_PORTS), g);
		chk(g & 16'h80BF, ports(1'b1, 1'b1, 6'h00));
		frame(4, 1'b1, 1'b1, 1'b0);
		rd(ad(IDX_INT_STATUS), g);
		chk(g, 16'h0000);
		bank(BANK_0);
		wr(ad(IDX_RX_CONTROL), 16'h0001);
		bank(BANK_2);
		// bad check, overrun and foreign address queue nothing
		frame(3 + rn(4), 1'b1, 1'b0, 1'b0);
		frame(4 + rn(4), 1'b1, 1'b1, 1'b1);
		frame(2 + rn(4), 1'b0, 1'b1, 1'b0);
		rd(ad(IDX_INT_STATUS), g);
		chk(g, 16'h0000);
		// two good frames queue in order
		frame(2 + rn(5), 1'b1, 1'b1, 1'b0);
		rd(ad(IDX_HEAD_PORTS), g);
		ha = g[13:8];
		chk(g & 16'h8000, 16'h0000);
		frame(2 + rn(5), 1'b1, 1'b1, 1'b0);
		rd(ad(IDX_INT_STATUS), g);
		chk(g, 16'h0001);
		rd(ad(IDX_HEAD_PORTS), g);
		chk(16'(g[13:8]), 16'(ha));
		wr(ad(IDX_COMMAND), CMD_RX_REMOVE);
		rd(ad(IDX_HEAD_PORTS), g);
		chk(g & 16'h8000, 16'h0000);
		pkt_chk(g[13:8]);
		wr(ad(IDX_COMMAND), CMD_RX_REMOVE);
		rd(ad(IDX_INT_STATUS), g);
		chk(g, 16'h0000);
		// good send, acknowledge, release
		bank(BANK_0);
		wr(ad(IDX_TX_CONTROL), 16'h0001);
		bank(BANK_2);
		p = 6'(rn(16));
		send(p, 1'b0);
		chk(16'(lp), 16'(p));
		rd(ad(IDX_INT_STATUS), g);
		chk(g, 16'h0002);
		wr(ad(IDX_INT_STATUS), 16'h0002);
		rd(ad(IDX_INT_STATUS), g);
		chk(g, 16'h0000);
		wr(ad(IDX_COMMAND), CMD_RELEASE);
		bank(BANK_0);
		rd(ad(IDX_LINK_STATUS), g);
		chk(g & 16'h0001, 16'h0001);
		// failed send halts sending until run is set again
		bank(BANK_2);
		p = 6'(rn(16));
		send(p, 1'b1);
		rd(ad(IDX_PKT_SELECT), sv);
		rd(ad(IDX_HEAD_PORTS), g);
		chk(g & 16'h80BF, ports(1'b1, 1'b0, p));
		wr(ad(IDX_INT_STATUS), 16'h0002);
		wr(ad(IDX_PKT_SELECT), g & 16'h003F);
		fail_next <= 1'b0;
		wr(ad(IDX_COMMAND), CMD_ENQUEUE);
		repeat (20) @(posedge aclk);
		chk(16'(starts), 16'h0002);
		bank(BANK_0);
		rd(ad(IDX_LINK_STATUS), g);
		chk(g & 16'h0001, 16'h0000);
		rd(ad(IDX_TX_CONTROL), g);
		chk(g, 16'h0000);
		wr(ad(IDX_TX_CONTROL), g | 16'h0001);
		wait_tq(60);
		chk(16'(lp), 16'(p));
		bank(BANK_2);
		wr(ad(IDX_INT_STATUS), 16'h0002);
		wr(ad(IDX_PKT_SELECT), sv);
		rd(ad(IDX_PKT_SELECT), g);
		chk(g & 16'h003F, sv & 16'h003F);
		// auto release leaves no completion entry
		bank(BANK_0);
		wr(ad(IDX_TX_CONTROL), 16'h0003);
		bank(BANK_2);
		send(6'(rn(16)), 1'b0);
		rd(ad(IDX_INT_STATUS), g);
		chk(g, 16'h0000);
		chk(16'(starts), 16'h0004);
		stop_test();
	end
endmodule
`default_nettype wire
